// [amsq_pkg.sv]
// Purpose: Constants shared by the converter mode sequencer
// Assumes: 20 MHz system clock
// Notes:   Counts derive from printed times
package amsq_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ         = 20000000;
  localparam int POR_DELAY_US   = 500;
  localparam int POR_CYCLES     = (POR_DELAY_US * (CLK_HZ / 1000000));
  localparam int START_NORM_X2  = 57;
  localparam int START_TURBO    = 105;
  localparam int START_NORM_CYC = (START_NORM_X2 + 1) / 2;
  localparam int MOD_DIV        = 4;

  // ----------------------------------------
  // Command bytes and bus addresses
  // ----------------------------------------
  localparam logic [6:0] CMD_RESET_HI = 7'h03;
  localparam logic [6:0] CMD_START_HI = 7'h04;
  localparam logic [6:0] CMD_SLEEP_HI = 7'h01;
  localparam logic [7:0] GC_RESET     = 8'h06;
  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [2:0] ADDR_PREFIX  = 3'h4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] DR_RESET     = 3'h0;

  typedef enum logic [2:0]
  {
    ST_LOWPWR  = 3'b000,
    ST_DELAY   = 3'b001,
    ST_CONVERT = 3'b010,
    ST_SLEEP   = 3'b011
  } amsq_state_type;

endpackage

// [amsq_i2c_slave.sv]
// Purpose: Two-wire slave front end decoding command bytes
// Assumes: scl and sda already synchronised
// Notes:   Reads are acknowledged like writes; bytes after a read address are still decoded as commands
`timescale 1ns/100ps
`default_nettype none
module amsq_i2c_slave
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [1:0] code_high,
  input  wire logic [1:0] code_low,
  output logic            sda_oe,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte,
  output logic            gc_reset
);

  // ----------------------------------------
  // Line events
  // ----------------------------------------
  logic       scl_d;
  logic       sda_d;
  logic       active;
  logic       is_gc;
  logic       first;
  logic       addressed;
  logic       armed;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [6:0] my_addr;
  wire        scl_rise  = scl & ~scl_d;
  wire        scl_fall  = ~scl & scl_d;
  wire        start_ev  = scl & scl_d & sda_d & ~sda;
  wire        stop_ev   = scl & scl_d & ~sda_d & sda;
  wire [7:0]  next_shift = {shift[6:0], sda};
  wire        byte_end  = scl_fall & (bit_cnt == 4'd7);
  wire        ack_end   = scl_fall & (bit_cnt == 4'd8);
  wire        addr_hit  = (shift[7:1] == my_addr);
  wire        gc_hit    = (shift[7:1] == amsq_pkg::GC_ADDR) & ~shift[0];

  always_ff @(posedge clk)
  begin
    scl_d <= scl;
    sda_d <= sda;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      my_addr <= {amsq_pkg::ADDR_PREFIX, 4'h0};
    else if (start_ev | (first & ~active))
      my_addr <= {amsq_pkg::ADDR_PREFIX, code_high, code_low};
  end

  always_ff @(posedge clk)
  begin
    if (reset | start_ev | stop_ev)
    begin
      active    <= start_ev;
      first     <= 1'b1;
      addressed <= 1'b0;
      armed     <= 1'b0;
      is_gc     <= 1'b0;
      bit_cnt   <= 4'd0;
      sda_oe    <= 1'b0;
      cmd_valid <= 1'b0;
      gc_reset  <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      gc_reset  <= 1'b0;
      // Fall that ends a start is not a bit
      if (scl_rise)
        armed <= 1'b1;
      if (scl_rise & active & bit_cnt < 4'd8)
        shift <= next_shift;
      if (byte_end)
      begin
        bit_cnt <= 4'd8;
        if (first)
        begin
          addressed <= (addr_hit & ~shift[0]) | gc_hit | (addr_hit & shift[0]);
          is_gc     <= gc_hit;
          sda_oe    <= addr_hit | gc_hit;
        end
        else if (addressed)
        begin
          sda_oe    <= 1'b1;
          cmd_valid <= ~is_gc;
          cmd_byte  <= shift;
          gc_reset  <= is_gc & (shift == amsq_pkg::GC_RESET);
        end
      end
      else if (ack_end)
      begin
        bit_cnt <= 4'd0;
        sda_oe  <= 1'b0;
        first   <= 1'b0;
      end
      else if (scl_fall & active & armed)
        bit_cnt <= bit_cnt + 4'd1;
    end
  end

endmodule
`default_nettype wire

// [amsq_sequencer.sv]
// Purpose: Reset, conversion and operating mode sequencer
// Assumes: Pins pass two flip-flops; converter core outside
// Notes:   Address codes come from pin-strap detection outside
//
// Summary of operation
// - Power-on, pin or command resets at once
// - Reset loads defaults, idles low-power
// - Hold reset 500 us after power-up
// - Bytes 06h/07h reset, no extra delay
// - General-call reset also resets
// - Mode bit needs start to apply
// - Single-shot: one conversion then low-power
// - Single-shot config write restarts one conversion
// - Continuous: next conversion starts immediately
// - Start delay 29 (28.5 rounded up) or 105 clocks
// - Continuous config write restarts conversion
// - Sleep waits for conversion end
// - Normal mode default, modulator quarter clock
// - Turbo doubles modulator clock if mod_div even as turbo sets; if odd, mod_enable stops
// - Sleep powers analog off, keeps config
// - Start wakes from sleep per mode
// - Bus lines driven only low
// - Address 100 plus two pin codes
// - Address re-sampled every transaction
// - Result settles in one conversion
// - Start 0000100x, sleep 0000001x
// - Act once command byte latched
// - General call acked, 06h resets
`timescale 1ns/100ps
`default_nettype none
module amsq_sequencer
#(
  parameter int POR_CYCLES = amsq_pkg::POR_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       reset_pin_n,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic [1:0] code_high,
  input  wire logic [1:0] code_low,
  input  wire logic       conversion_mode_select_bit,
  input  wire logic [2:0] data_rate_field,
  input  wire logic       turbo_select,
  input  wire logic       config_write,
  input  wire logic       conversion_done,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            soft_reset,
  output logic            por_busy,
  output logic            conv_start,
  output logic            conv_busy,
  output logic            result_load,
  output logic            analog_on,
  output logic            excitation_on,
  output logic            osc_on,
  output logic            mod_enable,
  output logic [2:0]      data_rate,
  output logic            turbo_active,
  output logic            continuous_active
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] hi_sync;
  logic [1:0] lo_sync;
  logic [1:0] hi_meta;
  logic [1:0] lo_meta;

  always_ff @(posedge clk)
  begin
    rst_sync <= {rst_sync[0], reset_pin_n};
    scl_sync <= {scl_sync[0], scl_pin};
    sda_sync <= {sda_sync[0], sda_pin};
    hi_meta  <= code_high;
    lo_meta  <= code_low;
    hi_sync  <= hi_meta;
    lo_sync  <= lo_meta;
  end

  // ----------------------------------------
  // Power-on hold
  // ----------------------------------------
  logic [$clog2(POR_CYCLES+1)-1:0] por_cnt;

  always_ff @(posedge clk)
  begin
    if (reset)
      por_cnt <= '0;
    else if (por_cnt != POR_CYCLES[$clog2(POR_CYCLES+1)-1:0])
      por_cnt <= por_cnt + 1'b1;
  end
  assign por_busy = (por_cnt != POR_CYCLES[$clog2(POR_CYCLES+1)-1:0]);

  // ----------------------------------------
  // Serial slave and command decode
  // ----------------------------------------
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       gc_reset;
  logic       slave_sda_oe;

  amsq_i2c_slave u_slave
  (
    .clk       (clk),
    .reset     (reset | por_busy),
    .scl       (scl_sync[1]),
    .sda       (sda_sync[1]),
    .code_high (hi_sync),
    .code_low  (lo_sync),
    .sda_oe    (slave_sda_oe),
    .cmd_valid (cmd_valid),
    .cmd_byte  (cmd_byte),
    .gc_reset  (gc_reset)
  );

  // never drive high, never touch clock
  assign sda_out = 1'b0;
  assign sda_oe  = slave_sda_oe;
  assign scl_out = 1'b0;
  assign scl_oe  = 1'b0;

  wire cmd_start = cmd_valid & (cmd_byte[7:1] == amsq_pkg::CMD_START_HI);
  wire cmd_sleep = cmd_valid & (cmd_byte[7:1] == amsq_pkg::CMD_SLEEP_HI);
  wire cmd_reset = cmd_valid & (cmd_byte[7:1] == amsq_pkg::CMD_RESET_HI);

  assign soft_reset = cmd_reset | gc_reset;
  wire   any_reset  = reset | por_busy | ~rst_sync[1] | soft_reset;

  // ----------------------------------------
  // Latched settings
  // ----------------------------------------
  logic mode_cont;
  logic sleep_pend;

  always_ff @(posedge clk)
  begin
    if (any_reset)
      mode_cont <= 1'b0;
    else if (cmd_start)
      mode_cont <= conversion_mode_select_bit;
  end

  always_ff @(posedge clk)
  begin
    if (any_reset)
    begin
      data_rate    <= amsq_pkg::DR_RESET;
      turbo_active <= 1'b0;
    end
    else
    begin
      data_rate    <= data_rate_field;
      turbo_active <= turbo_select;
    end
  end

  // ----------------------------------------
  // Modulator clock enable
  // ----------------------------------------
  logic [1:0] mod_div;

  always_ff @(posedge clk)
  begin
    if (any_reset)
      mod_div <= 2'd0;
    else
      mod_div <= mod_div + (turbo_active ? 2'd2 : 2'd1);
  end
  assign mod_enable = conv_busy & (mod_div == 2'd0);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  amsq_pkg::amsq_state_type st;
  amsq_pkg::amsq_state_type next_st;
  logic [6:0] dly;
  wire  [6:0] dly_load = turbo_active ? 7'(amsq_pkg::START_TURBO)
                                      : 7'(amsq_pkg::START_NORM_CYC);
  wire        restart  = config_write & (st == amsq_pkg::ST_CONVERT);

  always_comb
  begin
    next_st = st;
    case (st)
      amsq_pkg::ST_LOWPWR, amsq_pkg::ST_SLEEP:
        if (cmd_start)
          next_st = amsq_pkg::ST_DELAY;
      amsq_pkg::ST_DELAY:
        if (cmd_sleep)
          next_st = amsq_pkg::ST_SLEEP;
        else if (dly == 7'd1)
          next_st = amsq_pkg::ST_CONVERT;
      amsq_pkg::ST_CONVERT:
        if (cmd_start)
          next_st = amsq_pkg::ST_DELAY;
        else if (conversion_done & ~restart)
        begin
          if (sleep_pend | cmd_sleep)
            next_st = amsq_pkg::ST_SLEEP;
          else if (!mode_cont)
            next_st = amsq_pkg::ST_LOWPWR;
        end
      default:
        next_st = amsq_pkg::ST_LOWPWR;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (any_reset)
      st <= amsq_pkg::ST_LOWPWR;
    else
      st <= next_st;
  end

  always_ff @(posedge clk)
  begin
    if (any_reset | next_st != amsq_pkg::ST_DELAY)
      dly <= dly_load;
    else if (st == amsq_pkg::ST_DELAY)
      dly <= dly - 7'd1;
  end

  always_ff @(posedge clk)
  begin
    if (any_reset | st != amsq_pkg::ST_CONVERT)
      sleep_pend <= 1'b0;
    else if (cmd_sleep)
      sleep_pend <= 1'b1;
  end

  assign conv_start = (st == amsq_pkg::ST_DELAY && next_st == amsq_pkg::ST_CONVERT)
                    | restart
                    | (st == amsq_pkg::ST_CONVERT && conversion_done && !restart
                       && next_st == amsq_pkg::ST_CONVERT);
  assign result_load = (st == amsq_pkg::ST_CONVERT) & conversion_done & ~restart;
  assign conv_busy   = (st == amsq_pkg::ST_CONVERT);
  assign continuous_active = mode_cont;

  assign analog_on     = (st == amsq_pkg::ST_DELAY) | (st == amsq_pkg::ST_CONVERT);
  assign osc_on        = analog_on;
  assign excitation_on = (st != amsq_pkg::ST_SLEEP);

endmodule
`default_nettype wire

// [amsq_properties.sv]
// Purpose: Port checks of the mode sequencer
// Assumes: Bound to amsq_sequencer
// Notes:   Bounds follow the hand-over latencies
`timescale 1ns/100ps
`default_nettype none
module amsq_properties
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       reset_pin_n,
  input wire logic       config_write,
  input wire logic       conversion_done,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       soft_reset,
  input wire logic       por_busy,
  input wire logic       conv_start,
  input wire logic       conv_busy,
  input wire logic       result_load,
  input wire logic       analog_on,
  input wire logic       mod_enable,
  input wire logic [2:0] data_rate,
  input wire logic       turbo_active,
  input wire logic       continuous_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ------------------------------
  // Properties
  // ------------------------------
  sequence s_done;
    conv_busy && conversion_done && !config_write;
  endsequence
  property p_pins; !scl_oe && !scl_out && !sda_out; endproperty
  property p_por; por_busy |-> !conv_start; endproperty
  property p_dflt;
    $fell(reset) |-> !conv_busy && !turbo_active && data_rate == 3'h0;
  endproperty
  property p_soft; soft_reset |=> !conv_busy [*2]; endproperty
  property p_pin; !reset_pin_n [*4] |-> !conv_busy; endproperty
  property p_mod; mod_enable && !turbo_active |=> !mod_enable [*3]; endproperty
  property p_one; s_done ##0 !continuous_active |=> ##1 !conv_busy [*2]; endproperty
  property p_cont; s_done ##0 continuous_active |-> result_load; endproperty
  property p_cfg; config_write && conv_busy |-> ##[0:120] conv_start; endproperty
  property p_an; conv_busy |-> analog_on; endproperty
  a_pins: assert property (p_pins) else $error("bus line driven high");
  a_por: assert property (p_por) else $error("start during hold");
  a_dflt: assert property (p_dflt) else $error("reset defaults");
  a_soft: assert property (p_soft) else $error("soft reset");
  a_pin: assert property (p_pin) else $error("pin reset");
  a_mod: assert property (p_mod) else $error("modulator rate");
  a_one: assert property (p_one) else $error("single shot");
  a_cont: assert property (p_cont) else $error("no result load");
  a_cfg: assert property (p_cfg) else $error("no restart");
  a_an: assert property (p_an) else $error("analog off");
endmodule
`default_nettype wire

// [amsq_host.sv]
// Purpose: Two-wire bus master model
// Assumes: Four clocks per half bit
// Notes:   Open drain lines with pull-ups
`timescale 1ns/100ps
`default_nettype none
module amsq_host
(
  input  wire logic clk,
  input  wire logic sda_oe,
  output wire logic scl_pin,
  output wire logic sda_pin
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  int   cnt = 0;
  int   f8 = 0;
  assign scl_pin = ~scl_low;
  assign sda_pin = ~(sda_low | sda_oe);
  always @(posedge clk) cnt <= cnt + 1;
  task automatic hb;
    repeat (4) @(posedge clk);
  endtask
  task automatic start_bit;
    sda_low <= 1'b1;
    hb();
    scl_low <= 1'b1;
    hb();
  endtask
  // msb first, ack on ninth pulse
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low <= ~b[i];
      hb();
      scl_low <= 1'b0;
      hb();
      scl_low <= 1'b1;
      f8 = cnt;
      hb();
    end
    sda_low <= 1'b0;
    hb();
    scl_low <= 1'b0;
    hb();
    ack = ~sda_pin;
    scl_low <= 1'b1;
    hb();
  endtask
  task automatic stop_bit;
    sda_low <= 1'b1;
    hb();
    scl_low <= 1'b0;
    hb();
    sda_low <= 1'b0;
    hb();
  endtask
endmodule
`default_nettype wire

// [amsq_sequencer_tb.sv]
// Purpose: Self-checking bench of the sequencer
// Assumes: Hold shortened to 20 cycles
// Notes:   Start delay judged in a window, sync lag unknown
`timescale 1ns/100ps
`default_nettype none
module amsq_sequencer_tb;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       reset_pin_n = 1'b1;
  wire logic  scl_pin;
  wire logic  sda_pin;
  logic [1:0] code_high = 2'h0;
  logic [1:0] code_low = 2'h0;
  logic       conversion_mode_select_bit = 1'b0;
  logic       turbo_select = 1'b0;
  logic [2:0] data_rate_field = 3'h5;
  logic       excitation_on;
  logic       osc_on;
  logic       config_write = 1'b0;
  logic       conversion_done = 1'b0;
  logic       sda_oe;
  logic       soft_reset;
  logic       por_busy;
  logic       conv_start;
  logic       conv_busy;
  logic       analog_on;
  logic [2:0] data_rate;
  logic       turbo_active;
  logic       continuous_active;
  logic       ak;
  logic       sr = 1'b0;
  int         n_fail = 0;
  int         n_checks = 0;
  int         cyc = 0;
  int         n_cs = 0;
  int         t_cs = 0;
  int         n0;
  wire logic [7:0] me = {3'h4, code_high, code_low, 1'b0};
  amsq_sequencer #(.POR_CYCLES(20)) DUT
  (
    .clk, .reset, .reset_pin_n, .scl_pin, .sda_pin, .code_high, .code_low,
    .conversion_mode_select_bit, .data_rate_field, .turbo_select,
    .config_write, .conversion_done, .scl_out(), .scl_oe(), .sda_out(), .sda_oe,
    .soft_reset, .por_busy, .conv_start, .conv_busy, .result_load(), .analog_on,
    .excitation_on, .osc_on, .mod_enable(), .data_rate, .turbo_active,
    .continuous_active
  );
  amsq_host host (.clk, .sda_oe, .scl_pin, .sda_pin);
  initial forever #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (conv_start) n_cs <= n_cs + 1;
    if (conv_start) t_cs <= host.cnt;
    if (soft_reset) sr <= 1'b1;
    if (cyc == 40000) begin n_fail++; results(); end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin n_fail++; $display("BAD %s exp %h got %h", n, e, s); end
  endtask
  task automatic results;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n); repeat (n) @(posedge clk); endtask
  task automatic send(input logic [7:0] a, input logic [7:0] b);
    logic k;
    host.start_bit();
    host.put(a, ak);
    host.put(b, k);
    host.stop_bit();
  endtask
  task automatic wait_cs(input int m, input int lim);
    repeat (lim) if (n_cs <= m) @(posedge clk);
  endtask
  task automatic cfg;
    config_write <= 1'b1;
    tick(1);
    config_write <= 1'b0;
  endtask
  task automatic done;
    conversion_done <= 1'b1;
    tick(1);
    conversion_done <= 1'b0;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_addr;
    for (int i = 0; i < 16; i++)
    begin
      code_high <= i[3:2];
      code_low <= i[1:0];
      send({3'h4, i[3:0], 1'b0}, 8'h00);
      chk("ack", ak, 1);
    end
    send(8'hA0, 8'h00);
    chk("nak", ak, 0);
    $display("t_addr done");
  endtask
  task automatic t_conv(input logic tb, input logic [7:0] lo, input logic [7:0] hi);
    turbo_select <= tb;
    cfg();
    n0 = n_cs;
    send(me, {7'h04, tb});
    wait_cs(n0, 150);
    chk("dly", 8'(t_cs - host.f8) inside {[lo:hi]}, 1);
    chk("turbo", turbo_active, tb);
    tick(3);
    done();
    tick(40);
    chk("once", 8'(n_cs - n0), 1);
    chk("low", {osc_on, excitation_on}, 2'b01);
    send(me, 8'h08);
    tick(100);
    cfg();
    wait_cs(n0 + 2, 150);
    chk("abort", 8'(n_cs - n0), 3);
    done();
    $display("t_conv done");
  endtask
  task automatic t_cont;
    turbo_select <= 1'b0;
    conversion_mode_select_bit <= 1'b1;
    n0 = n_cs;
    send(me, 8'h08);
    wait_cs(n0, 60);
    tick(3);
    done();
    wait_cs(n0 + 1, 40);
    chk("next", 8'(n_cs - n0), 2);
    tick(3);
    cfg();
    wait_cs(n0 + 2, 60);
    chk("restart", 8'(n_cs - n0), 3);
    n0 = n_cs;
    send(me, 8'h03);
    chk("finish", conv_busy, 1);
    done();
    tick(60);
    chk("sleep", {analog_on, osc_on, excitation_on, 5'(n_cs - n0)}, 0);
    send(me, 8'h08);
    wait_cs(n0, 60);
    chk("wake", 8'(n_cs - n0), 1);
    reset_pin_n <= 1'b0;
    tick(6);
    reset_pin_n <= 1'b1;
    chk("pin", conv_busy, 0);
    n0 = n_cs;
    tick(60);
    chk("idle", 8'(n_cs - n0), 0);
    $display("t_cont done");
  endtask
  task automatic t_rst;
    for (int i = 0; i < 3; i++)
    begin
      sr <= 1'b0;
      send(i < 2 ? me : 8'h00, 8'h06 + 8'(i % 2));
      chk("ack", ak, 1);
      chk("soft", sr, 1);
    end
    $display("t_rst done");
  endtask
  initial
  begin
    tick(2);
    reset <= 1'b0;
    tick(1);
    chk("hold", por_busy, 1);
    chk("mode", continuous_active, 0);
    tick(30);
    chk("free", por_busy, 0);
    chk("rate", data_rate, 3'h5);
    t_addr();
    t_conv(1'b0, 8'd29, 8'd36);
    t_conv(1'b1, 8'd105, 8'd112);
    t_cont();
    t_rst();
    results();
  end
endmodule
bind amsq_sequencer amsq_properties u_chk
(
  .clk, .reset, .reset_pin_n, .config_write, .conversion_done, .scl_out, .scl_oe,
  .sda_out, .soft_reset, .por_busy, .conv_start, .conv_busy, .result_load,
  .analog_on, .mod_enable, .data_rate, .turbo_active, .continuous_active
);
`default_nettype wire
